// *** logic/rsw_ref_switch.sv ***
// Reference input selection and holdover control for loop 1 of a
// dual-loop clock cleaner. Assumes a single 200 MHz clock, inputs
// synchronous to it, and a one-cycle pd1_tick per loop-1 comparison.
`timescale 1ns/100ps
`default_nettype none
`include "rsw_map.svh"

// Contract
// - Modes 0, 1, 2 always use input 0, 1, 2 as active.
// - Manual and pin modes run the selected buffer despite its enable bit.
// - Manual mode enters holdover on lock fall; exit checks selected input.
// - Mode 3: pins 00, 01, 10 pick inputs 0, 1, 2; 11 holdover.
// - In mode 3 any select pin change raises a switch event.
// - A select pin set as output reads as 0.
// - Invert bit flips both select pins before decoding.
// - Pin mode, holdover off: switch to new input at once.
// - Pin mode, holdover on: hold, then switch once exit is met.
// - Mode 4 picks enabled inputs in order 0, 1, 2 on events.
// - Entering auto modes keeps current input; host preselects manually.
// - Mode 4 lock fall raises event; lock must return before next one.
// - Tuning rail crossing with detection on enters holdover.
// - Mode 4 with holdover: hold, advance, exit when input qualifies.
// - Mode 4 without holdover: advance and keep until next event.
// - Mode 6 decodes pins: pin0 high input 0, 10 input 1, 00 input 2.
// - Mode 6 lock loss raises event; hold then exit, or switch direct.
// - Holdover tri-states the charge pump and drives a fixed tuning value.
// - Holdover is enabled by its mode bit; force bit holds manually.
// - Manual DAC bit selects fixed value; else tracking; rail conflicts.
// - Tracked value updates every divider ticks while tracking is on, outside holdover.
// - Lock detect reads low during holdover while locking continues.
// - Holdover ends on exit condition or holdover enable toggled off.
module rsw_ref_switch (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    // Register port
    input  wire rsw_pkg::rsw_bus_req_s  bus_req,
    output logic [`RSW_DATA_W-1:0]      bus_rdata,
    // Select pins
    input  wire logic [1:0]             sel_pin_in,
    output logic [1:0]                  sel_pin_out,
    output logic [1:0]                  sel_pin_oe,
    // Loop 1 status
    input  wire logic                   loop1_lock_detect,
    input  wire logic                   hold_exit_ok,
    input  wire logic                   tune_rail_high,
    input  wire logic                   tune_rail_low,
    input  wire logic                   pd1_tick,
    input  wire rsw_pkg::rsw_dac_t      tune_sample,
    // Loop 1 control
    output logic [1:0]                  active_input,
    output logic [2:0]                  ref_buf_enable,
    output logic                        holdover_active,
    output logic                        loop1_lock_gated,
    output logic                        charge_pump_tristate,
    output logic                        dac_drive_enable,
    output rsw_pkg::rsw_dac_t           loop1_dac_value,
    output logic                        switch_event
);

    rsw_pkg::rsw_state_s st_reg;
    rsw_pkg::rsw_state_s st_next;

    rsw_pkg::rsw_cfg_s   cfg;
    logic [1:0]          pins;
    logic                manual_mode;
    logic                pin_mode;
    logic                auto_prio;
    logic                auto_pin;
    logic                lock_eff;
    logic                lock_fell;
    logic                pin_event;
    logic                auto_event;
    logic                manual_loss;
    logic                rail_hit;
    rsw_pkg::rsw_ref_t   pin_sel;
    rsw_pkg::rsw_ref_t   apin_sel;
    rsw_pkg::rsw_ref_t   prio_next;
    logic                has_next;
    logic [2:0]          active_1h;
    logic                div_hit;

    assign cfg = st_reg.cfg;

    // Next enabled input after the current one, walking 0, 1, 2 around
    function automatic logic [2:0] next_enabled(
        input rsw_pkg::rsw_ref_t cur,
        input logic [2:0]        en
    );
        logic [2:0]        res;
        rsw_pkg::rsw_ref_t cand;
        res = {1'b0, cur};
        for (int k = 2; k >= 0; k--) begin
            cand = rsw_pkg::rsw_ref_t'((32'(cur) + 32'(k) + 1) % 3);
            if (en[cand]) begin
                res = {1'b1, cand};
            end
        end
        return res;
    endfunction

    always_comb begin
        // Output-direction pins read as 0 after the polarity flip
        pins[0] = cfg.dir0_out ? 1'b0 : (sel_pin_in[0] ^ cfg.pin_inv);
        pins[1] = cfg.dir1_out ? 1'b0 : (sel_pin_in[1] ^ cfg.pin_inv);
    end

    assign manual_mode = (cfg.mode <= 3'h2);
    assign pin_mode    = (cfg.mode == 3'h3);
    assign auto_prio   = (cfg.mode == 3'h4);
    assign auto_pin    = (cfg.mode == 3'h6);

    // Lock as seen by switching logic is forced low in holdover
    assign lock_eff  = loop1_lock_detect & (st_reg.hold == rsw_pkg::RSW_RUN);
    assign lock_fell = st_reg.lock_prev & ~lock_eff;

    assign pin_sel  = pins;
    assign apin_sel = pins[0] ? 2'h0 : (pins[1] ? 2'h1 : 2'h2);

    assign {has_next, prio_next} = next_enabled(st_reg.active, cfg.ref_en);

    assign pin_event   = pin_mode & (pins != st_reg.pins_prev);
    // Loss events only count once lock has returned since the last one
    assign auto_event  = st_reg.armed & lock_fell
                         & ((auto_prio & ~cfg.lld_dis) | auto_pin);
    assign manual_loss = manual_mode & lock_fell & ~cfg.lld_dis;
    assign rail_hit    = cfg.rail_en & (tune_rail_high | tune_rail_low);

    always_comb begin
        active_1h = 3'h0;
        active_1h[st_reg.active] = 1'b1;
    end

    assign div_hit = pd1_tick & (st_reg.div_cnt >= cfg.dac_div - 1'b1);

    always_comb begin
        st_next = st_reg;
        st_next.event_q   = 1'b0;
        st_next.lock_prev = lock_eff;
        st_next.pins_prev = pins;
        st_next.hold_en_prev = cfg.hold_en;
        st_next.rdata     = '0;

        // Re-arm the switch logic once lock comes back
        if (lock_eff) begin
            st_next.armed = 1'b1;
        end

        // Register writes
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                `RSW_OFS_CTRL: begin
                    st_next.cfg.mode =
                        bus_req.wdata[`RSW_CTRL_MODE_LSB +: 3];
                    st_next.cfg.hold_en  = bus_req.wdata[`RSW_CTRL_HOLD_EN];
                    st_next.cfg.force_hold = bus_req.wdata[`RSW_CTRL_FORCE];
                    st_next.cfg.lld_dis  = bus_req.wdata[`RSW_CTRL_LLD_DIS];
                    st_next.cfg.rail_en  = bus_req.wdata[`RSW_CTRL_RAIL_EN];
                    st_next.cfg.pin_inv  = bus_req.wdata[`RSW_CTRL_PIN_INV];
                    st_next.cfg.dir0_out = bus_req.wdata[`RSW_CTRL_DIR0];
                    st_next.cfg.dir1_out = bus_req.wdata[`RSW_CTRL_DIR1];
                    st_next.cfg.ref_en   =
                        bus_req.wdata[`RSW_CTRL_REF_LSB +: 3];
                    st_next.cfg.track_en = bus_req.wdata[`RSW_CTRL_TRACK];
                    st_next.cfg.dac_fixed_value  = bus_req.wdata[`RSW_CTRL_DAC_FIXED_VALUE];
                end
                `RSW_OFS_DAC: begin
                    st_next.cfg.dac_fixed = bus_req.wdata[`RSW_DAC_W-1:0];
                    st_next.cfg.dac_div   =
                        bus_req.wdata[`RSW_DAC_DIV_LSB +: `RSW_DIV_W];
                end
                default: begin
                end
            endcase
        end

        // Register reads, answered in the next cycle
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                `RSW_OFS_CTRL: begin
                    st_next.rdata[`RSW_CTRL_MODE_LSB +: 3] = cfg.mode;
                    st_next.rdata[`RSW_CTRL_HOLD_EN]  = cfg.hold_en;
                    st_next.rdata[`RSW_CTRL_FORCE]    = cfg.force_hold;
                    st_next.rdata[`RSW_CTRL_LLD_DIS]  = cfg.lld_dis;
                    st_next.rdata[`RSW_CTRL_RAIL_EN]  = cfg.rail_en;
                    st_next.rdata[`RSW_CTRL_PIN_INV]  = cfg.pin_inv;
                    st_next.rdata[`RSW_CTRL_DIR0]     = cfg.dir0_out;
                    st_next.rdata[`RSW_CTRL_DIR1]     = cfg.dir1_out;
                    st_next.rdata[`RSW_CTRL_REF_LSB +: 3] = cfg.ref_en;
                    st_next.rdata[`RSW_CTRL_TRACK]    = cfg.track_en;
                    st_next.rdata[`RSW_CTRL_DAC_FIXED_VALUE]  = cfg.dac_fixed_value;
                end
                `RSW_OFS_DAC: begin
                    st_next.rdata[`RSW_DAC_W-1:0] = cfg.dac_fixed;
                    st_next.rdata[`RSW_DAC_DIV_LSB +: `RSW_DIV_W] =
                        cfg.dac_div;
                end
                `RSW_OFS_STAT: begin
                    st_next.rdata[1:0] = st_reg.active;
                    st_next.rdata[2]   = (st_reg.hold == rsw_pkg::RSW_HOLD);
                    st_next.rdata[3]   = lock_eff;
                    st_next.rdata[4]   = st_reg.bad_mode;
                    // Tracking cannot coexist with rail detection
                    st_next.rdata[5]   = cfg.track_en & ~cfg.dac_fixed_value
                                         & cfg.rail_en;
                    st_next.rdata[7:6] = st_reg.pending;
                end
                `RSW_OFS_TRACK: begin
                    st_next.rdata[`RSW_DAC_W-1:0] = st_reg.tracked;
                end
                default: begin
                end
            endcase
        end

        st_next.bad_mode = (cfg.mode == 3'h5) | (cfg.mode == 3'h7);

        // Active input selection per mode
        if (manual_mode) begin
            st_next.active  = cfg.mode[1:0];
            st_next.pending = cfg.mode[1:0];
        end else if (pin_mode) begin
            if (pin_event || st_reg.pins_prev != pins) begin
                st_next.pending = pin_sel;
                st_next.event_q = 1'b1;
                if (pin_sel != `RSW_SEL_HOLD && !cfg.hold_en) begin
                    st_next.active = pin_sel;
                end
            end
            if (lock_fell && !cfg.lld_dis) begin
                st_next.event_q = 1'b1;
            end
        end else if (auto_prio && auto_event) begin
            st_next.event_q = 1'b1;
            st_next.armed   = 1'b0;
            // No other enabled input leaves the current one in place
            if (has_next) begin
                st_next.active  = prio_next;
                st_next.pending = prio_next;
            end
        end else if (auto_pin && auto_event) begin
            st_next.event_q = 1'b1;
            st_next.armed   = 1'b0;
            st_next.pending = apin_sel;
            st_next.active  = apin_sel;
        end
        // Entering an auto mode keeps the active input untouched; modes 5
        // and 7 fall through every branch above.

        // Holdover state machine
        unique case (st_reg.hold)
            rsw_pkg::RSW_RUN: begin
                if (cfg.force_hold) begin
                    st_next.hold = rsw_pkg::RSW_HOLD;
                end else if (cfg.hold_en) begin
                    if (rail_hit) begin
                        st_next.hold = rsw_pkg::RSW_HOLD;
                    end else if (manual_loss) begin
                        st_next.hold = rsw_pkg::RSW_HOLD;
                    end else if (pin_event) begin
                        st_next.hold = rsw_pkg::RSW_HOLD;
                    end else if (pin_mode && lock_fell && !cfg.lld_dis) begin
                        st_next.hold = rsw_pkg::RSW_HOLD;
                    end else if (auto_event) begin
                        st_next.hold = rsw_pkg::RSW_HOLD;
                    end
                end
                if (pin_mode && pin_sel == `RSW_SEL_HOLD) begin
                    st_next.hold = rsw_pkg::RSW_HOLD;
                end
            end
            rsw_pkg::RSW_HOLD: begin
                if (cfg.force_hold) begin
                    st_next.hold = rsw_pkg::RSW_HOLD;
                end else if (pin_mode && pin_sel == `RSW_SEL_HOLD) begin
                    st_next.hold = rsw_pkg::RSW_HOLD;
                end else if (!cfg.hold_en) begin
                    // Turning holdover off is the host's way out
                    st_next.hold = rsw_pkg::RSW_RUN;
                    if (pin_mode) begin
                        st_next.active = pin_sel;
                    end
                end else if (hold_exit_ok) begin
                    st_next.hold = rsw_pkg::RSW_RUN;
                    if (pin_mode) begin
                        st_next.active = st_reg.pending;
                    end
                end
            end
        endcase

        // Tracked DAC pacing; frozen in holdover to keep the last good value
        if (cfg.track_en && pd1_tick) begin
            if (div_hit) begin
                st_next.div_cnt = '0;
                if (st_reg.hold == rsw_pkg::RSW_RUN) begin
                    st_next.tracked = tune_sample;
                end
            end else begin
                st_next.div_cnt = st_reg.div_cnt + 1'b1;
            end
        end
        if (!cfg.track_en) begin
            st_next.div_cnt = '0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '{
                cfg: '{
                    mode:       `RSW_MODE_RST,
                    hold_en:    1'b0,
                    force_hold: 1'b0,
                    lld_dis:    1'b0,
                    rail_en:    1'b0,
                    pin_inv:    1'b0,
                    dir0_out:   1'b0,
                    dir1_out:   1'b0,
                    ref_en:     `RSW_REF_EN_RST,
                    track_en:   1'b0,
                    dac_fixed_value:    1'b0,
                    dac_fixed:  `RSW_DAC_FIX_RST,
                    dac_div:    `RSW_DAC_DIV_RST
                },
                hold:         rsw_pkg::RSW_RUN,
                active:       2'h0,
                pending:      2'h0,
                pins_prev:    2'h0,
                lock_prev:    1'b0,
                armed:        1'b0,
                hold_en_prev: 1'b0,
                div_cnt:      '0,
                tracked:      '0,
                event_q:      1'b0,
                bad_mode:     1'b0,
                rdata:        '0
            };
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs
    assign bus_rdata       = st_reg.rdata;
    assign active_input    = st_reg.active;
    assign holdover_active = (st_reg.hold == rsw_pkg::RSW_HOLD);
    assign switch_event    = st_reg.event_q;

    // In manual and pin modes the selected buffer runs even if software disabled it
    assign ref_buf_enable = cfg.ref_en
                            | ((manual_mode | pin_mode) ? active_1h : 3'h0);

    assign loop1_lock_gated     = lock_eff;
    assign charge_pump_tristate = holdover_active;
    assign dac_drive_enable     = holdover_active;
    assign loop1_dac_value      = cfg.dac_fixed_value ? cfg.dac_fixed
                                              : st_reg.tracked;

    // Pins set as outputs report holdover status
    assign sel_pin_oe  = {cfg.dir1_out, cfg.dir0_out};
    assign sel_pin_out = {holdover_active, holdover_active};

endmodule
`default_nettype wire

// *** include/rsw_map.svh ***
// Register offsets, field positions, reset values and widths of the
// reference input switch. Assumes a byte-addressed register port.
`ifndef RSW_MAP_SVH
`define RSW_MAP_SVH

`define RSW_ADDR_W        8
`define RSW_DATA_W        32
`define RSW_DAC_W         10
`define RSW_DIV_W         10

`define RSW_OFS_CTRL      8'h00
`define RSW_OFS_DAC       8'h04
`define RSW_OFS_STAT      8'h08
`define RSW_OFS_TRACK     8'h0C

`define RSW_CTRL_MODE_LSB 0
`define RSW_CTRL_HOLD_EN  3
`define RSW_CTRL_FORCE    4
`define RSW_CTRL_LLD_DIS  5
`define RSW_CTRL_RAIL_EN  6
`define RSW_CTRL_PIN_INV  7
`define RSW_CTRL_DIR0     8
`define RSW_CTRL_DIR1     9
`define RSW_CTRL_REF_LSB  10
`define RSW_CTRL_TRACK    13
`define RSW_CTRL_DAC_FIXED_VALUE  14
`define RSW_DAC_DIV_LSB   16

`define RSW_MODE_RST      3'h0
`define RSW_REF_EN_RST    3'h7
`define RSW_DAC_FIX_RST   10'h200
`define RSW_DAC_DIV_RST   10'h001
`define RSW_SEL_HOLD      2'h3

`endif

// *** include/rsw_pkg.sv ***
// Types shared by the reference input switch and its bench.
// Widths come from rsw_map.svh, which this file includes below.
`include "rsw_map.svh"

package rsw_pkg;

    typedef logic [2:0]             rsw_mode_t;
    typedef logic [1:0]             rsw_ref_t;
    typedef logic [`RSW_DAC_W-1:0]  rsw_dac_t;
    typedef logic [`RSW_DIV_W-1:0]  rsw_div_t;

    typedef enum logic {RSW_RUN, RSW_HOLD} rsw_hold_e;

    // Register port request
    typedef struct packed {
        logic [`RSW_ADDR_W-1:0] addr;
        logic [`RSW_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } rsw_bus_req_s;

    // Software configuration
    typedef struct packed {
        rsw_mode_t  mode;
        logic       hold_en;
        logic       force_hold;
        logic       lld_dis;
        logic       rail_en;
        logic       pin_inv;
        logic       dir0_out;
        logic       dir1_out;
        logic [2:0] ref_en;
        logic       track_en;
        logic       dac_fixed_value;
        rsw_dac_t   dac_fixed;
        rsw_div_t   dac_div;
    } rsw_cfg_s;

    // Select pin group: input, output and output enable per pin
    typedef struct packed {
        logic [1:0] in;
        logic [1:0] out;
        logic [1:0] oe;
    } rsw_pins_s;

    typedef struct packed {
        rsw_cfg_s               cfg;
        rsw_hold_e              hold;
        rsw_ref_t               active;
        rsw_ref_t               pending;
        logic [1:0]             pins_prev;
        logic                   lock_prev;
        logic                   armed;
        logic                   hold_en_prev;
        rsw_div_t               div_cnt;
        rsw_dac_t               tracked;
        logic                   event_q;
        logic                   bad_mode;
        logic [`RSW_DATA_W-1:0] rdata;
    } rsw_state_s;

endpackage

// *** verif/rsw_host_model.sv ***
// Host model: select pin drivers and loop-1 status.
// Assumes tasks are called from the bench's clocked sequence.
`timescale 1ns/100ps
`default_nettype none
module rsw_host_model (
    // Clock
    input  wire logic       clk,
    // Select pins
    input  wire logic [1:0] pin_out,
    input  wire logic [1:0] pin_oe,
    output logic      [1:0] pin_lvl,
    // Loop 1 status
    output logic            lock,
    output logic            exit_ok
);
    logic [1:0] drive;
    initial begin
        drive   = 2'h0;
        lock    = 1'b1;
        exit_ok = 1'b0;
    end
    // Host lets go of a pin the device drives
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & drive);
    task automatic set_pins(input logic [1:0] v);
        @(posedge clk) drive <= v;
    endtask
    task automatic set_exit(input logic v);
        @(posedge clk) exit_ok <= v;
    endtask
    // One comparison out of window, then relock between events
    task automatic lose_lock();
        @(posedge clk) lock <= 1'b0;
        @(posedge clk) lock <= 1'b1;
    endtask
endmodule
`default_nettype wire

// *** verif/rsw_ref_switch_checker.sv ***
// Port assertions on the reference switch, bound below.
// Assumes config changes only by bus_req writes.
`timescale 1ns/100ps
`default_nettype none
`include "rsw_map.svh"
module rsw_ref_switch_checker (
    input wire logic                  clk,
    input wire logic                  arst_n,
    input wire rsw_pkg::rsw_bus_req_s bus_req,
    input wire logic [1:0]            sel_pin_in,
    input wire logic [1:0]            sel_pin_oe,
    input wire logic                  loop1_lock_detect,
    input wire logic [1:0]            active_input,
    input wire logic [2:0]            ref_buf_enable,
    input wire logic                  holdover_active,
    input wire logic                  loop1_lock_gated,
    input wire logic                  charge_pump_tristate,
    input wire logic                  dac_drive_enable,
    input wire rsw_pkg::rsw_dac_t     loop1_dac_value,
    input wire logic                  switch_event
);
    // Shadow of the control fields, so the mode is known here
    logic [15:0] ctrl_reg;
    logic [9:0]  fix_reg;
    logic [1:0]  dec;
    logic        m3;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= 16'h1C00;
            fix_reg  <= `RSW_DAC_FIX_RST;
        end else if (bus_req.wr && bus_req.addr == `RSW_OFS_CTRL) begin
            ctrl_reg <= bus_req.wdata[15:0];
        end else if (bus_req.wr && bus_req.addr == `RSW_OFS_DAC) begin
            fix_reg <= bus_req.wdata[9:0];
        end
    end
    assign dec = (sel_pin_in ^ {2{ctrl_reg[7]}}) & ~ctrl_reg[9:8];
    assign m3  = ctrl_reg[2:0] == 3'h3;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence pin_change;
        m3 && $stable(ctrl_reg) && $changed(dec);
    endsequence
    sequence manual_held;
        ctrl_reg[2:0] < 3'h3 && $stable(ctrl_reg);
    endsequence
    lock_gating_a: assert property (
        loop1_lock_gated == (loop1_lock_detect && !holdover_active))
        else $error("lock not gated");
    pump_release_a: assert property (
        charge_pump_tristate == holdover_active
        && dac_drive_enable == holdover_active)
        else $error("pump not released");
    manual_pick_a: assert property (
        manual_held |=> active_input == $past(ctrl_reg[1:0]))
        else $error("manual input wrong");
    manual_buffer_a: assert property (
        manual_held |=> ref_buf_enable[active_input])
        else $error("manual buffer off");
    pin_event_a: assert property (
        pin_change |=> switch_event)
        else $error("no pin switch event");
    pin_switch_a: assert property (
        m3 && !ctrl_reg[3] && switch_event && $past(dec) != 2'h3
        |-> active_input == $past(dec))
        else $error("pin select decode wrong");
    pin_hold_a: assert property (
        pin_change ##0 ctrl_reg[3] |=> holdover_active)
        else $error("pin switch not held");
    bad_mode_a: assert property (
        ctrl_reg[2] && ctrl_reg[0] |=> $stable(active_input))
        else $error("bad mode moved input");
    fixed_dac_a: assert property (
        ctrl_reg[14] |-> loop1_dac_value == fix_reg)
        else $error("fixed dac value not used");
    pin_dir_a: assert property (
        sel_pin_oe == ctrl_reg[9:8])
        else $error("pin direction wrong");
endmodule
bind rsw_ref_switch rsw_ref_switch_checker u_chk (.*);
`default_nettype wire

// *** verif/test_ref_input_switch_holdover.sv ***
// Bench of the reference switch: reset, mode table, pin, holdover, dac.
// Assumes rsw_pkg is compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "rsw_map.svh"
module test_ref_input_switch_holdover;
    typedef struct packed {
        logic [2:0] m;
        logic [2:0] en;
        logic [1:0] p;
        logic [1:0] a;
    } rsw_row_s;
    logic                  clk = 1'b0;
    logic                  arst_n = 1'b0;
    rsw_pkg::rsw_bus_req_s req = '0;
    logic [31:0]           rdata;
    logic [1:0]            pin_lvl, pin_out, pin_oe, act;
    logic [2:0]            buf_en;
    logic                  lock, exit_ok, hold, gated, cp_tri, dac_en, sw_ev;
    logic [1:0]            rail = 2'h0;
    logic                  tick = 1'b0;
    rsw_pkg::rsw_dac_t     sample = '0;
    rsw_pkg::rsw_dac_t     dac_val;
    rsw_row_s              r;
    int                    n_errors = 0;
    int                    n_checks = 0;
    // Packed {mode, enables, pins, expected input}
    rsw_row_s rows [11] = '{10'h000, 10'h081, 10'h102, 10'h1F5, 10'h1FA,
        10'h1F0, 10'h379, 10'h372, 10'h37C, 10'h271, 10'h272};
    always #2.5 clk = ~clk;
    rsw_host_model h (.*);
    rsw_ref_switch DUT (.clk(clk), .arst_n(arst_n), .bus_req(req),
        .bus_rdata(rdata), .sel_pin_in(pin_lvl), .sel_pin_out(pin_out),
        .sel_pin_oe(pin_oe), .loop1_lock_detect(lock),
        .hold_exit_ok(exit_ok), .tune_rail_high(rail[1]),
        .tune_rail_low(rail[0]), .pd1_tick(tick), .tune_sample(sample),
        .active_input(act), .ref_buf_enable(buf_en),
        .holdover_active(hold), .loop1_lock_gated(gated),
        .charge_pump_tristate(cp_tri), .dac_drive_enable(dac_en),
        .loop1_dac_value(dac_val), .switch_event(sw_ev));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) req <= '0;
    endtask
    task automatic ctl(input logic [15:0] v);
        wr(`RSW_OFS_CTRL, {16'h0, v});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk) req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk) req <= '0;
        #1 chk("read", rdata, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        cyc(1);
        chk("reset active", 32'(act), 32'h0);
        chk("reset buffers", 32'(buf_en), 32'h7);
        chk("reset hold", 32'(hold), 32'h0);
        rd(`RSW_OFS_CTRL, 32'h1C00);
        rd(`RSW_OFS_DAC, 32'h1_0200);
        wr(`RSW_OFS_STAT, 32'hFFFF_FFFF);
        rd(`RSW_OFS_STAT, 32'h8);
        rd(8'h10, 32'h0);
        cyc(1);
        chk("rdata idle", rdata, 32'h0);
        $display("reset test done");
        // Mode 4 rows rely on the active input left by the row before each (the mode 6 row, then the first mode 4 row)
        foreach (rows[i]) begin
            r = rows[i];
            ctl({3'h0, r.en, 4'h0, r.m == 3'h3, 2'h0, r.m});
            h.set_pins(r.p);
            cyc(3);
            h.lose_lock();
            cyc(4);
            chk("active", 32'(act), 32'(r.a));
            chk("buffer", 32'(buf_en[r.a]), 32'h1);
            $display("row %0d done", i);
        end
        // Pin select with holdover; host keeps lock loss off
        ctl(16'h1C23);
        h.set_pins(2'h1);
        ctl(16'h1C2B);
        h.set_pins(2'h2);
        cyc(3);
        chk("hold", 32'(hold), 32'h1);
        chk("held input", 32'(act), 32'h1);
        chk("gated", 32'(gated), 32'h0);
        chk("pump", 32'(cp_tri), 32'h1);
        h.set_exit(1'b1);
        cyc(3);
        chk("exit", 32'(hold), 32'h0);
        chk("new input", 32'(act), 32'h2);
        h.set_exit(1'b0);
        ctl(16'h1C23);
        h.set_pins(2'h3);
        cyc(3);
        chk("pins hold", 32'(hold), 32'h1);
        h.set_pins(2'h0);
        ctl(16'h1CA3);
        h.set_pins(2'h2);
        cyc(3);
        chk("inverted", 32'(act), 32'h1);
        ctl(16'h1D23);
        cyc(3);
        chk("pin out", 32'(act), 32'h2);
        $display("pin tests done");
        ctl(16'h1C01);
        ctl(16'h1C05);
        h.set_pins(2'h1);
        h.lose_lock();
        cyc(3);
        chk("bad mode", 32'(act), 32'h1);
        ctl(16'h1C10);
        cyc(2);
        chk("force", 32'(hold), 32'h1);
        ctl(16'h1C00);
        ctl(16'h1C08);
        cyc(2);
        h.lose_lock();
        cyc(3);
        chk("manual hold", 32'(hold), 32'h1);
        h.set_exit(1'b1);
        cyc(3);
        chk("manual exit", 32'(hold), 32'h0);
        h.set_exit(1'b0);
        ctl(16'h1C48);
        rail <= 2'h1;
        cyc(3);
        chk("rail hold", 32'(hold), 32'h1);
        rail <= 2'h0;
        ctl(16'h1C00);
        cyc(2);
        chk("disable exit", 32'(hold), 32'h0);
        $display("holdover tests done");
        wr(`RSW_OFS_DAC, 32'h2_0155);
        ctl(16'h5C00);
        cyc(2);
        chk("fixed dac", 32'(dac_val), 32'h155);
        ctl(16'h3C00);
        sample <= 10'h0AB;
        repeat (4) begin
            @(posedge clk) tick <= 1'b1;
            @(posedge clk) tick <= 1'b0;
        end
        cyc(2);
        chk("tracked dac", 32'(dac_val), 32'h0AB);
        rd(`RSW_OFS_TRACK, 32'hAB);
        $display("dac test done");
        end_of_test();
    end
endmodule
`default_nettype wire
